//--- rtl/stdt_pkg.sv
// package for the synced timer and delay trigger block: register map, field positions, resets, types
// assumes one 20 MHz clock domain and a 32-bit Avalon-MM master in front of the block
package stdt_pkg;
    // timers: three identical register groups, one 16-byte stride each
    localparam int NUM_TMR = 3;
    localparam logic [7:0] OFS_TMR_CTRL = 8'h00;
    localparam logic [7:0] OFS_TMR_INIT = 8'h04;
    localparam logic [7:0] OFS_TMR_MOD = 8'h08;
    localparam logic [7:0] OFS_TMR_CNT = 8'h0C;
    localparam logic [7:0] OFS_TMR_LAST = 8'h2C;
    localparam logic [7:0] OFS_MATCH7 = 8'h30;
    localparam logic [7:0] OFS_ROUTE = 8'h34;
    // delay trigger block
    localparam logic [7:0] OFS_DB_CTRL = 8'h40;
    localparam logic [7:0] OFS_DB_MOD = 8'h44;
    localparam logic [7:0] OFS_DB_INTERRUPT_DELAY_VALUE = 8'h48;
    localparam logic [7:0] OFS_DB_CHCTRL = 8'h4C;
    localparam logic [7:0] OFS_DB_STAT = 8'h50;
    localparam logic [7:0] OFS_DB_DLY0 = 8'h60;
    localparam logic [7:0] OFS_DB_DLY7 = 8'h7C;
    // timer control fields
    localparam int TC_GATE = 0;
    localparam int TC_CLKSEL = 1;
    localparam int TC_DRIVE = 2;
    // delay block control fields
    localparam int DB_EN = 0;
    localparam int DB_CONTINUOUS_RUN = 1;
    localparam int DB_LOAD_MODE_SELECT = 2;
    localparam int DB_ERRIE = 4;
    localparam int DB_IRQEN = 5;
    localparam int DB_TRIGGER_INPUT_SELECT = 8;
    localparam int DB_PRESC = 12;
    localparam int DB_PRESCALE_MULTIPLIER = 16;
    localparam int DB_LOAD_OK = 18;
    localparam int DB_IRQF = 19;
    localparam int DB_ERRF = 20;
    localparam int DB_TOS = 8;
    // load modes
    localparam logic [1:0] LOAD_MODE_SELECT_NOW = 2'h0;
    localparam logic [1:0] LOAD_MODE_SELECT_MOD = 2'h1;
    localparam logic [1:0] LOAD_MODE_SELECT_TRIG = 2'h2;
    localparam logic [1:0] LOAD_MODE_SELECT_EITHER = 2'h3;
    // reset values and fixed routes
    localparam logic [15:0] DB_MOD_RST = 16'hFFFF;
    localparam logic [15:0] TMR_MOD_RST = 16'hFFFF;
    localparam logic [3:0] ROUTE_RST = 4'h0;
    localparam logic [3:0] ROUTE_TMR_IDX = 4'hB;
    localparam logic [3:0] TRIGGER_INPUT_SELECT_ROUTED = 4'h0;
    localparam int NUM_PRE = 8;

    typedef enum logic {DB_IDLE, DB_RUN} stdt_db_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } stdt_av_req_t;

    typedef struct packed {
        logic [NUM_PRE-1:0] pretrig;
        logic trig;
    } stdt_conv_t;
endpackage

//--- rtl/stdt_top.sv
// synced pwm timers, trigger router and delay trigger block behind an Avalon-MM slave
// assumes the converter shares i_clk; external trigger pins are asynchronous
//
// Overview of operation
// - gated timer advances only while the global time base is high
// - any full-word write to a counter loads it from its initial-value register
// - input clock selected as counter clock, divide by one; gating still stops it
// - master drive-out bit raises the time base so gated timers start together
// - counter runs from initial value up to modulo, then reloads initial value
// - master reload trigger ORed with channel 7 match into one trigger
// - router forwards selected input, index 11 being the timer trigger
// - each input trigger yields eight delayed pre-triggers selecting converter slots
// - eight pre-triggers ORed into one conversion start trigger
// - all delays counted from the detected input trigger by one counter
// - 16-bit modulus limit, reset to 0xFFFF so it never cuts delays
// - load mode b10 copies buffers at first trigger after load-ok written
// - trigger select 0 picks router output; prescale and multiplier 0 run full rate
// - without bypass each pre-trigger has enable and select bits, fires at its delay
// - after a pre-trigger stay locked until conversion done and result read
// - pre-trigger while locked flags sequence error and may interrupt
// - after sequence error no converter triggers until software clears it
// - delay interrupt flag sets when counter reaches interrupt delay value
// - block runs only when enabled; non-continuous runs one sequence per trigger
`timescale 1ns/1ns
module stdt_top import stdt_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire stdt_av_req_t i_av,
    output logic [31:0] o_av_readdata,
    output logic o_av_waitrequest,
    input wire logic [15:0] i_ext_trig,
    input wire logic i_conv_done,
    input wire logic i_result_read,
    output stdt_conv_t o_conv,
    output logic o_delay_pulse,
    output logic o_delay_irq,
    output logic o_err_irq,
    output logic o_timebase
);
    logic ack_r;
    logic wr_ok;
    logic [31:0] rdata_r;
    logic [2:0] tctrl_r [NUM_TMR];
    logic [15:0] tinit_r [NUM_TMR];
    logic [15:0] tmod_r [NUM_TMR];
    logic [15:0] tcnt_r [NUM_TMR];
    logic [NUM_TMR-1:0] adv;
    logic [NUM_TMR-1:0] cnt_wr;
    logic [15:0] match7_r;
    logic tmr_trig_r;
    logic gtb;
    logic [3:0] route_r;
    logic [15:0] ext_s1_r;
    logic [15:0] ext_s2_r;
    logic [15:0] route_in;
    logic routed_r;
    logic routed_prev_r;
    logic [31:0] dctrl_r;
    logic [15:0] mod_buf_r, interrupt_delay_value_buf_r, mod_act_r, interrupt_delay_value_act_r;
    logic [15:0] dly_buf_r [NUM_PRE];
    logic [15:0] dly_act_r [NUM_PRE];
    logic [7:0] ch_en_r, ch_tos_r;
    logic load_ok_r, irqf_r, errf_r, lock_r, done_seen_r;
    stdt_db_state_t state_r;
    logic [15:0] dcnt_r;
    logic [15:0] div_r;
    logic [15:0] period;
    logic [5:0] prescale_multiplier_f;
    logic tick, trig_ev, sel_in, at_mod, do_load, release_lock;
    logic [NUM_PRE-1:0] pre_hit;
    logic db_en, irq_hit;

    // single wait state: request seen, answer at the next edge with waitrequest low
    assign o_av_waitrequest = (i_av.read | i_av.write) & ~ack_r;
    assign wr_ok = i_av.write & ack_r & (i_av.byteenable == 4'hF);
    assign o_av_readdata = rdata_r;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_av.read | i_av.write) & ~ack_r;
        end
    end

    // read mux, captured in the wait cycle so data stands at the answering edge
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_r <= 32'h0;
        end else if (i_av.read & ~ack_r) begin
            rdata_r <= 32'h0;
            if (i_av.address <= OFS_TMR_LAST) begin
                case (i_av.address[3:0])
                    OFS_TMR_CTRL[3:0]: rdata_r <= {29'h0, tctrl_r[i_av.address[5:4]]};
                    OFS_TMR_INIT[3:0]: rdata_r <= {16'h0, tinit_r[i_av.address[5:4]]};
                    OFS_TMR_MOD[3:0]: rdata_r <= {16'h0, tmod_r[i_av.address[5:4]]};
                    OFS_TMR_CNT[3:0]: rdata_r <= {16'h0, tcnt_r[i_av.address[5:4]]};
                    default: rdata_r <= 32'h0;
                endcase
            end else if (i_av.address >= OFS_DB_DLY0 && i_av.address <= OFS_DB_DLY7) begin
                rdata_r <= {16'h0, dly_buf_r[i_av.address[4:2]]};
            end else begin
                case (i_av.address)
                    OFS_MATCH7: rdata_r <= {16'h0, match7_r};
                    OFS_ROUTE: rdata_r <= {28'h0, route_r};
                    OFS_DB_CTRL: rdata_r <= {11'h0, errf_r, irqf_r, load_ok_r, dctrl_r[17:0]};
                    OFS_DB_MOD: rdata_r <= {16'h0, mod_buf_r};
                    OFS_DB_INTERRUPT_DELAY_VALUE: rdata_r <= {16'h0, interrupt_delay_value_buf_r};
                    OFS_DB_CHCTRL: rdata_r <= {16'h0, ch_tos_r, ch_en_r};
                    OFS_DB_STAT: rdata_r <= {13'h0, done_seen_r, lock_r, state_r == DB_RUN, dcnt_r};
                    default: rdata_r <= 32'h0;
                endcase
            end
        end
    end

    // timer control and period registers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                tctrl_r[i] <= 3'h0;
                tinit_r[i] <= 16'h0;
                tmod_r[i] <= TMR_MOD_RST;
            end
            match7_r <= 16'h0;
            route_r <= ROUTE_RST;
        end else if (wr_ok) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                if (i_av.address[5:4] == 2'(i) && i_av.address <= OFS_TMR_LAST) begin
                    if (i_av.address[3:0] == OFS_TMR_CTRL[3:0]) tctrl_r[i] <= i_av.writedata[2:0];
                    if (i_av.address[3:0] == OFS_TMR_INIT[3:0]) tinit_r[i] <= i_av.writedata[15:0];
                    if (i_av.address[3:0] == OFS_TMR_MOD[3:0]) tmod_r[i] <= i_av.writedata[15:0];
                end
            end
            if (i_av.address == OFS_MATCH7) match7_r <= i_av.writedata[15:0];
            if (i_av.address == OFS_ROUTE) route_r <= i_av.writedata[3:0];
        end
    end

    // global time base comes from the master timer (timer 0) drive-out bit
    assign gtb = tctrl_r[0][TC_DRIVE];
    assign o_timebase = gtb;

    // advance enables: clock selected at divide one, held while gated and time base low
    always_comb begin
        for (int i = 0; i < NUM_TMR; i++) begin
            adv[i] = tctrl_r[i][TC_CLKSEL] & (~tctrl_r[i][TC_GATE] | gtb);
            cnt_wr[i] = wr_ok && i_av.address == (OFS_TMR_CNT + 8'(i * 16));
        end
    end

    // counters; a counter write never stores the written value
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_TMR; i++) tcnt_r[i] <= 16'h0;
        end else begin
            for (int i = 0; i < NUM_TMR; i++) begin
                if (cnt_wr[i]) begin
                    tcnt_r[i] <= tinit_r[i];
                end else if (adv[i]) begin
                    tcnt_r[i] <= (tcnt_r[i] == tmod_r[i]) ? tinit_r[i] : tcnt_r[i] + 16'h1;
                end
            end
        end
    end

    // master trigger: reload (init) event ORed with channel 7 match, one pulse
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tmr_trig_r <= 1'b0;
        end else begin
            tmr_trig_r <= adv[0] & ((tcnt_r[0] == tmod_r[0]) | (tcnt_r[0] == match7_r));
        end
    end

    // pins are asynchronous, so two flops before the router looks at them
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ext_s1_r <= 16'h0;
            ext_s2_r <= 16'h0;
        end else begin
            ext_s1_r <= i_ext_trig;
            ext_s2_r <= ext_s1_r;
        end
    end

    // router: input 11 is hard-wired to the timer trigger, the select is software's only say
    always_comb begin
        route_in = ext_s2_r;
        route_in[ROUTE_TMR_IDX] = tmr_trig_r;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            routed_r <= 1'b0;
            routed_prev_r <= 1'b0;
        end else begin
            routed_r <= route_in[route_r];
            routed_prev_r <= sel_in;
        end
    end

    // delay block input: select 0 is the only wired source, others read as idle
    assign sel_in = (dctrl_r[DB_TRIGGER_INPUT_SELECT +: 4] == TRIGGER_INPUT_SELECT_ROUTED) ? routed_r : 1'b0;
    assign db_en = dctrl_r[DB_EN];
    assign trig_ev = db_en & sel_in & ~routed_prev_r;

    // tick divider: prescale 2^p times multiplier 1/10/20/40; 0/0 ticks every clock
    always_comb begin
        case (dctrl_r[DB_PRESCALE_MULTIPLIER +: 2])
            2'h0: prescale_multiplier_f = 6'h01;
            2'h1: prescale_multiplier_f = 6'h0A;
            2'h2: prescale_multiplier_f = 6'h14;
            default: prescale_multiplier_f = 6'h28;
        endcase
        period = 16'({10'h0, prescale_multiplier_f} << dctrl_r[DB_PRESC +: 3]) - 16'h1;
    end
    assign tick = (div_r == 16'h0);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_r <= 16'h0;
        end else if (trig_ev || tick) begin
            div_r <= trig_ev ? 16'h0 : period;
        end else begin
            div_r <= div_r - 16'h1;
        end
    end

    // sequence counter started by the detected trigger, limited by the modulus
    assign at_mod = (state_r == DB_RUN) & tick & (dcnt_r == mod_act_r);
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !db_en) begin
            state_r <= DB_IDLE;
            dcnt_r <= 16'h0;
        end else if (trig_ev) begin
            state_r <= DB_RUN;
            dcnt_r <= 16'h0;
        end else if (state_r == DB_RUN && tick) begin
            case (state_r)
                DB_RUN: begin
                    if (at_mod) begin
                        dcnt_r <= 16'h0;
                        state_r <= dctrl_r[DB_CONTINUOUS_RUN] ? DB_RUN : DB_IDLE;
                    end else begin
                        dcnt_r <= dcnt_r + 16'h1;
                    end
                end
                default: state_r <= DB_IDLE;
            endcase
        end
    end

    // compare hits: gated by tick, so each hit lasts one clock even while a prescaled counter holds its value
    always_comb begin
        for (int n = 0; n < NUM_PRE; n++) begin
            pre_hit[n] = (state_r == DB_RUN) & tick & ch_en_r[n] & ch_tos_r[n] & (dcnt_r == dly_act_r[n]);
        end
    end
    assign irq_hit = (state_r == DB_RUN) & tick & (dcnt_r == interrupt_delay_value_act_r);

    // converter outputs, silenced while a sequence error stands
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_conv <= '0;
            o_delay_pulse <= 1'b0;
        end else begin
            o_conv.pretrig <= errf_r ? 8'h0 : pre_hit;
            o_conv.trig <= ~errf_r & (|pre_hit);
            o_delay_pulse <= irq_hit;
        end
    end

    // load of active delay set from buffers, chosen by load mode
    always_comb begin
        case (dctrl_r[DB_LOAD_MODE_SELECT +: 2])
            LOAD_MODE_SELECT_NOW: do_load = load_ok_r;
            LOAD_MODE_SELECT_MOD: do_load = load_ok_r & at_mod;
            LOAD_MODE_SELECT_TRIG: do_load = load_ok_r & trig_ev;
            LOAD_MODE_SELECT_EITHER: do_load = load_ok_r & (at_mod | trig_ev);
            default: do_load = 1'b0;
        endcase
    end

    // delay block buffers and control bits
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dctrl_r <= 32'h0;
            mod_buf_r <= DB_MOD_RST;
            interrupt_delay_value_buf_r <= 16'h0;
            ch_en_r <= 8'h0;
            ch_tos_r <= 8'h0;
            for (int n = 0; n < NUM_PRE; n++) dly_buf_r[n] <= 16'h0;
        end else if (wr_ok) begin
            if (i_av.address == OFS_DB_CTRL) dctrl_r <= {14'h0, i_av.writedata[17:0]};
            if (i_av.address == OFS_DB_MOD) mod_buf_r <= i_av.writedata[15:0];
            if (i_av.address == OFS_DB_INTERRUPT_DELAY_VALUE) interrupt_delay_value_buf_r <= i_av.writedata[15:0];
            if (i_av.address == OFS_DB_CHCTRL) begin
                ch_en_r <= i_av.writedata[7:0];
                ch_tos_r <= i_av.writedata[DB_TOS +: 8];
            end
            if (i_av.address >= OFS_DB_DLY0 && i_av.address <= OFS_DB_DLY7) dly_buf_r[i_av.address[4:2]] <= i_av.writedata[15:0];
        end
    end

    // active set: a trigger-mode load waits, so a half-written set is never used
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mod_act_r <= DB_MOD_RST;
            interrupt_delay_value_act_r <= 16'h0;
            load_ok_r <= 1'b0;
            for (int n = 0; n < NUM_PRE; n++) dly_act_r[n] <= 16'h0;
        end else begin
            if (do_load) begin
                mod_act_r <= mod_buf_r;
                interrupt_delay_value_act_r <= interrupt_delay_value_buf_r;
                for (int n = 0; n < NUM_PRE; n++) dly_act_r[n] <= dly_buf_r[n];
            end
            if (wr_ok && i_av.address == OFS_DB_CTRL && i_av.writedata[DB_LOAD_OK] && i_av.writedata[DB_EN]) begin
                load_ok_r <= 1'b1;
            end else if (do_load || !db_en) begin
                load_ok_r <= 1'b0;
            end
        end
    end

    // lock and flags; hardware set wins over a software clear in the same cycle
    assign release_lock = (done_seen_r | i_conv_done) & i_result_read;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lock_r <= 1'b0;
            done_seen_r <= 1'b0;
            irqf_r <= 1'b0;
            errf_r <= 1'b0;
        end else begin
            if (o_conv.trig) begin
                lock_r <= 1'b1;
                done_seen_r <= 1'b0;
            end else if (release_lock) begin
                lock_r <= 1'b0;
                done_seen_r <= 1'b0;
            end else if (lock_r && i_conv_done) begin
                done_seen_r <= 1'b1;
            end
            if (irq_hit) begin
                irqf_r <= 1'b1;
            end else if (wr_ok && i_av.address == OFS_DB_CTRL && !i_av.writedata[DB_IRQF]) begin
                irqf_r <= 1'b0;
            end
            if (o_conv.trig && lock_r) begin
                errf_r <= 1'b1;
            end else if (wr_ok && i_av.address == OFS_DB_CTRL && !i_av.writedata[DB_ERRF]) begin
                errf_r <= 1'b0;
            end
        end
    end

    assign o_delay_irq = irqf_r & dctrl_r[DB_IRQEN];
    assign o_err_irq = errf_r & dctrl_r[DB_ERRIE];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    gate_hold_a: assert property (tctrl_r[1][TC_GATE] && !gtb && !cnt_wr[1] |=> $stable(tcnt_r[1]))
        else $error("gated counter moved without time base");
    cnt_load_a: assert property (cnt_wr[2] |=> tcnt_r[2] == $past(tinit_r[2]))
        else $error("counter write did not load initial value");
    wrap_a: assert property (adv[0] && !cnt_wr[0] && tcnt_r[0] == tmod_r[0] |=> tcnt_r[0] == $past(tinit_r[0]))
        else $error("counter did not reload at modulo");
    tmr_trig_a: assert property (adv[0] && tcnt_r[0] == match7_r |=> tmr_trig_r)
        else $error("channel 7 match gave no trigger");
    conv_or_a: assert property (pre_hit != 8'h0 && !errf_r |=> o_conv.trig && o_conv.pretrig == $past(pre_hit))
        else $error("pre-trigger not forwarded to converter");
    seq_err_a: assert property (o_conv.trig && lock_r |=> errf_r ##1 o_conv.trig == 1'b0)
        else $error("sequence error not flagged or triggers not stopped");
    err_stop_a: assert property (errf_r |=> o_conv.pretrig == 8'h0)
        else $error("pre-trigger issued during sequence error");
    irq_set_a: assert property (irq_hit |=> irqf_r && o_delay_pulse ##1 !o_delay_pulse)
        else $error("delay interrupt not flagged as one pulse");
    db_off_a: assert property (!db_en |=> state_r == DB_IDLE)
        else $error("delay block ran while disabled");
    trig_load_a: assert property (dctrl_r[DB_LOAD_MODE_SELECT +: 2] == LOAD_MODE_SELECT_TRIG && load_ok_r && trig_ev |=> mod_act_r == $past(mod_buf_r) && !load_ok_r)
        else $error("buffered load missed on trigger");
    lock_hold_a: assert property (lock_r && !i_result_read && !o_conv.trig |=> lock_r)
        else $error("lock released without result read");
endmodule // stdt_top

//--- testbench/stdt_conv_model.sv
// converter stand-in: each conversion start restarts the wait; done comes when it runs out, then a result read
// assumes it shares i_clk and i_rstn with the delay block
`timescale 1ns/1ns
module stdt_conv_model import stdt_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire stdt_conv_t i_conv,
    input wire logic i_slow,
    output logic o_done,
    output logic o_read
);
    logic [7:0] wait_r;
    // slow mode outlasts the pre-trigger spacing on purpose, to provoke a lock overrun
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wait_r <= 8'h00;
        end else if (i_conv.trig) begin
            wait_r <= i_slow ? 8'h3C : 8'h03;
        end else if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
        end
    end
    // done first, result read one cycle later, so the lock can only drop after both
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_done <= 1'b0;
            o_read <= 1'b0;
        end else begin
            o_done <= wait_r == 8'h01;
            o_read <= o_done;
        end
    end
endmodule // stdt_conv_model

//--- testbench/tb_top.sv
// self-checking bench: timers, router and delay block against a reference kept in the bench
// assumes the converter stand-in on the far side and a 20 MHz clock
`timescale 1ns/1ns
module tb_top import stdt_pkg::*; ;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    stdt_av_req_t av = '0;
    logic [15:0] noise = 16'h0000;
    logic pulse = 1'b0;
    logic slow = 1'b0;
    logic done, rd, tbase, dpulse, dirq, eirq, wreq;
    logic [31:0] rdata, q, v;
    stdt_conv_t conv;
    logic [7:0] en;
    int mismatches = 0, samples_checked = 0, cyc = 0, pin, ibuf, iact = 0;
    int pq[8][$];
    int dq[$];
    int bufv[8];
    int act[8];

    stdt_top stdt_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_av(av), .o_av_readdata(rdata),
        .o_av_waitrequest(wreq), .i_ext_trig((noise & ~(16'h0001 << pin)) | ({15'h0000, pulse} << pin)),
        .i_conv_done(done), .i_result_read(rd), .o_conv(conv), .o_delay_pulse(dpulse),
        .o_delay_irq(dirq), .o_err_irq(eirq), .o_timebase(tbase));
    stdt_conv_model stdt_conv_model_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_conv(conv), .i_slow(slow),
        .o_done(done), .o_read(rd));

    always #25 i_clk = ~i_clk;

    // unselected pins toggle freely so a router leak shows up as stray pulses
    always @(posedge i_clk) noise <= 16'($urandom);

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // monitor: outputs seen at each edge are the pulses of the cycle before
    always @(posedge i_clk) begin
        cyc++;
        for (int n = 0; n < 8; n++) if (conv.pretrig[n] === 1'b1) pq[n].push_back(cyc);
        if (dpulse === 1'b1) dq.push_back(cyc);
        if (i_rstn) chk({31'h0, |conv.pretrig}, {31'h0, conv.trig});
    end

    // one bus access; the request stands until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        av <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: d};
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0);
        q = rdata;
        av <= '0;
        // the slave promises exactly one wait state; only the watchdog ends a hung wait
        chk(32'h2, 32'(n));
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(e, q);
    endtask

    task automatic fire(input int span);
        foreach (pq[n]) pq[n].delete();
        dq.delete();
        @(posedge i_clk);
        pulse <= 1'b1;
        repeat (3) @(posedge i_clk);
        pulse <= 1'b0;
        repeat (span) @(posedge i_clk);
    endtask

    // the interrupt-delay pulse is the time reference, since pin sync latency is not ours
    task automatic seq(input int fired);
        chk(fired, dq.size());
        for (int n = 0; n < 8; n++) begin
            chk(fired & en[n], pq[n].size());
            if (fired && en[n] && dq.size() == 1 && pq[n].size() == 1) chk(dq[0] - iact + act[n], pq[n][0]);
        end
    endtask

    task automatic finish_test;
        $display("counts: checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        pin = $urandom(62349) % 11;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        rdchk(OFS_DB_MOD, 32'h0000FFFF);
        rdchk(OFS_TMR_MOD, 32'h0000FFFF);
        rdchk(8'hF0, 32'h00000000);
        $display("test reset done");
        // gated timers are loaded and clocked while the time base is still low
        for (int t = 0; t < 3; t++) begin
            acc(1'b1, 8'(16 * t) + OFS_TMR_INIT, t ? 32'h00000100 : 32'h00000000);
            acc(1'b1, 8'(16 * t) + OFS_TMR_CNT, $urandom);
            acc(1'b1, 8'(16 * t) + OFS_TMR_CTRL, 32'h00000003);
        end
        acc(1'b1, OFS_TMR_MOD, 32'h00000040);
        acc(1'b1, OFS_MATCH7, 32'h00000020);
        rdchk(8'h1C, 32'h00000100);
        acc(1'b1, OFS_TMR_CTRL, 32'h00000007);
        // time base rises at the landing edge; a read samples two edges after the previous access ends
        rdchk(8'h1C, 32'h00000101);
        rdchk(8'h2C, 32'h00000104);
        chk(32'h1, {31'h0, tbase});
        acc(1'b1, 8'h14, 32'h0000FFFE);
        acc(1'b1, 8'h18, 32'h00000002);
        acc(1'b1, 8'h1C, 32'h0);
        // reload lands at -2, so the count runs FFFE, FFFF, 0, 1, 2 and wraps to FFFE
        rdchk(8'h1C, 32'h0000FFFF);
        rdchk(8'h1C, 32'h00000002);
        rdchk(8'h1C, 32'h00000000);
        $display("test timers done");
        acc(1'b1, OFS_ROUTE, 32'(pin));
        en = 8'($urandom);
        v = $urandom;
        acc(1'b1, OFS_DB_CHCTRL, {16'h0000, v[7:0], en});
        en = en & v[7:0];
        // first pass arms load-ok, second only rewrites buffers and must keep the old delays
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 8; n++) begin
                bufv[n] = 8 + 16 * n + $urandom % 6;
                acc(1'b1, OFS_DB_DLY0 + 8'(4 * n), 32'(bufv[n]));
            end
            ibuf = 4 + $urandom % 140;
            acc(1'b1, OFS_DB_INTERRUPT_DELAY_VALUE, 32'(ibuf));
            rdchk(OFS_DB_DLY7, 32'(bufv[7]));
            acc(1'b1, OFS_DB_CTRL, {13'h0000, k == 0, 18'h00039});
            @(posedge i_clk);
            chk(32'h0, {31'h0, dirq});
            if (k == 0) begin
                act = bufv;
                iact = ibuf;
            end
            fire(200);
            seq(1);
            chk(32'h1, {31'h0, dirq});
            $display("test delay sequence %0d done", k);
        end
        acc(1'b1, OFS_DB_CHCTRL, 32'h0000FFFF);
        slow <= 1'b1;
        fire(200);
        chk(32'h1, pq[0].size());
        chk(32'h0, pq[2].size() + pq[7].size());
        chk(32'h1, {31'h0, eirq});
        slow <= 1'b0;
        acc(1'b1, OFS_DB_CTRL, 32'h00000039);
        @(posedge i_clk);
        chk(32'h0, {31'h0, eirq});
        $display("test sequence error done");
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, OFS_DB_CTRL, k ? 32'h00000139 : 32'h00000038);
            fire(200);
            seq(0);
        end
        $display("test disabled paths done");
        acc(1'b1, OFS_ROUTE, {28'h0000000, ROUTE_TMR_IDX});
        acc(1'b1, OFS_DB_CTRL, 32'h00000039);
        pin = 16;
        fire(325);
        chk(32'h1, {31'h0, pq[0].size() >= 8});
        $display("test timer trigger done");
        finish_test();
    end
endmodule // tb_top
